// ### rtl/vmsp_defs.svh
`ifndef VMSP_DEFS_SVH
`define VMSP_DEFS_SVH

// ==========================================================
// Register byte addresses
`define VMSP_ADDR_STATUS 8'h00
`define VMSP_ADDR_MASK 8'h04
`define VMSP_ADDR_STATE 8'h08
`define VMSP_ADDR_CODE 8'h0c

// ==========================================================
// Event bit positions in status and mask
`define VMSP_EV_WIDTH 5
`define VMSP_EV_MODE 0
`define VMSP_EV_GOOD_LOST 1
`define VMSP_EV_SER_WORD 2
`define VMSP_EV_DUTY 3
`define VMSP_EV_SHOOT 4

// ==========================================================
// Duty limit as a fraction of the switching interval
`define VMSP_DUTY_NUM 933
`define VMSP_DUTY_DEN 1000

// ==========================================================
// Reset values and fixed codes
`define VMSP_MASK_RESET 5'h00
`define VMSP_CODE_RESET 8'h00
`define VMSP_FIXED_CODE 8'h00

`endif

// ### rtl/vmsp_pkg.sv
package vmsp_pkg;

  // ==========================================================
  // Operating mode, latched on the enable rising edge
  typedef enum logic [2:0]
  {
    VMSP_OFF = 3'b001,
    VMSP_SERIAL = 3'b010,
    VMSP_PARALLEL = 3'b100
  } vmsp_mode_type;

endpackage

// ### rtl/vmsp_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-flop synchroniser bank for pin inputs
module vmsp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1; // First stage, read only by second

  // Two flops in series, cleared by reset
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

`default_nettype wire

// ### rtl/vmsp_top.sv
// Function
// - Enable rise samples select: low serial, high parallel
// - Serial mode: pins are fixed-enable, data, clock
// - Parallel mode: pins decode into reference code
// - Upper parallel bits ignored in serial mode
// - Serial pin pull-downs on except in serial mode; others always
// - Fixed-enable input picks fixed or serial operation
// - Enable low disables both controllers
// - Power-ok low: boot code; high: serial runs
// - Good low on window exit or fault
// - Good low until soft-start completes
// - Each pulse limited to 93.3% of interval
// - Sense strapped high disables phase three/four
// - Strap to ground enables droop, supply disables
// - Upper gate waits for lower gate off
// - Each pulse rises at most once per interval
`include "vmsp_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module vmsp_top #(
  parameter int PERIOD_CYCLES = 20,
  parameter int SER_BITS = 8,
  parameter logic [7:0] FIXED_CODE = `VMSP_FIXED_CODE
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // APB slave
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Enable and shared code pins
  input wire logic enable_pin_in,
  input wire logic mode_select_code_bit1_in,
  input wire logic code_bit0_or_fixed_voltage_enable_in,
  input wire logic code_bit2_or_serial_data_in,
  output logic code_bit2_or_serial_data_out,
  output logic code_bit2_or_serial_data_oe_out,
  input wire logic code_bit3_or_serial_clock_in,
  input wire logic parallel_code_bit4_in,
  input wire logic parallel_code_bit5_in,
  input wire logic system_power_ok_input_in,
  output logic pulldown_serial_pins_out,
  output logic pulldown_other_pins_out,
  // Analog monitors and straps
  input wire logic [1:0] window_fault_in,
  input wire logic overcurrent_fault_in,
  input wire logic soft_start_done_in,
  input wire logic frequency_set_strap_in,
  input wire logic [3:0] phase_current_sense_negative_in,
  // Regulator control
  output logic core_enable_out,
  output logic northbridge_enable_out,
  output logic droop_enable_out,
  output logic fixed_voltage_mode_out,
  output logic [7:0] ref_code_out,
  output logic outputs_good_indication_out,
  // Phase pulses
  input wire logic [3:0] phase_demand_in,
  output logic [1:0] phase_pulse_out,
  output logic phase_three_pulse_output_out,
  output logic phase_four_pulse_output_out,
  // Northbridge gate drive
  input wire logic northbridge_demand_in,
  input wire logic northbridge_lower_gate_drive_in,
  output logic northbridge_upper_gate_drive_out,
  output logic northbridge_lower_gate_drive_out,
  // Interrupt
  output logic irq_out
);

  // ==========================================================
  // Constants
  localparam int MAX_ON = (PERIOD_CYCLES * `VMSP_DUTY_NUM) / `VMSP_DUTY_DEN;
  localparam logic [15:0] MAX_ON_C = 16'(MAX_ON);
  localparam logic [15:0] LAST_CNT = 16'(PERIOD_CYCLES - 1);
  localparam logic [3:0] LAST_BIT = 4'(SER_BITS - 1);

  // ==========================================================
  // Input synchronisers
  logic [17:0] pins_raw; // Raw pin levels
  logic [17:0] pins_s; // Synchronised pin levels

  assign pins_raw = {northbridge_lower_gate_drive_in, phase_current_sense_negative_in,
                     frequency_set_strap_in, soft_start_done_in, overcurrent_fault_in,
                     window_fault_in, system_power_ok_input_in, parallel_code_bit5_in,
                     parallel_code_bit4_in, code_bit3_or_serial_clock_in,
                     code_bit2_or_serial_data_in, code_bit0_or_fixed_voltage_enable_in,
                     mode_select_code_bit1_in, enable_pin_in};

  vmsp_sync #(.WIDTH(18)) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  logic en_s, sel_s, b0_s, b2_s, b3_s, b4_s, b5_s, system_power_ok_input_s; // Synced pins
  logic oc_s, ss_s, fs_s, lg_mon_s; // Synced monitors
  logic [1:0] win_s; // Synced window faults
  logic [3:0] phase_current_sense_negative_s; // Synced sense straps

  assign {lg_mon_s, phase_current_sense_negative_s, fs_s, ss_s, oc_s, win_s, system_power_ok_input_s, b5_s, b4_s, b3_s, b2_s,
          b0_s, sel_s, en_s} = pins_s;

  // ==========================================================
  // Mode latch on enable rising edge
  vmsp_pkg::vmsp_mode_type mode; // Latched mode
  logic en_prev; // Enable one cycle ago
  logic en_rise; // Enable rising edge
  logic run; // Controllers running
  logic [3:0] phase_on; // Active phases
  logic droop; // Latched droop strap

  assign en_rise = en_s & ~en_prev;
  assign run = (mode != vmsp_pkg::VMSP_OFF);

  // Enable edge detector
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      en_prev <= 1'b0;
    else
      en_prev <= en_s;
  end

  // Mode machine
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      mode <= vmsp_pkg::VMSP_OFF;
    else
    begin
      case (mode)
        vmsp_pkg::VMSP_OFF:
          if (en_rise)
            mode <= sel_s ? vmsp_pkg::VMSP_PARALLEL : vmsp_pkg::VMSP_SERIAL;
        vmsp_pkg::VMSP_SERIAL, vmsp_pkg::VMSP_PARALLEL:
          if (!en_s)
            mode <= vmsp_pkg::VMSP_OFF;
        default:
          mode <= vmsp_pkg::VMSP_OFF;
      endcase
    end
  end

  // Strap capture at enable rise
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      phase_on <= 4'h3;
      droop <= 1'b0;
    end
    else if (en_rise)
    begin
      phase_on <= {~phase_current_sense_negative_s[3], ~phase_current_sense_negative_s[2], 2'b11};
      droop <= ~fs_s;
    end
  end

  // ==========================================================
  // Serial receiver on the processor clock
  logic sclk_prev; // Serial clock one cycle ago
  logic [7:0] ser_shift; // Incoming bits
  logic [7:0] ser_word; // Last complete word
  logic [3:0] ser_cnt; // Bits received
  logic ser_done; // Word complete pulse
  logic ser_active; // Protocol running

  assign ser_active = (mode == vmsp_pkg::VMSP_SERIAL) & system_power_ok_input_s;

  // Shift data on each serial clock rise
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sclk_prev <= 1'b0;
      ser_shift <= 8'h00;
      ser_word <= `VMSP_CODE_RESET;
      ser_cnt <= 4'h0;
      ser_done <= 1'b0;
    end
    else
    begin
      sclk_prev <= b3_s;
      ser_done <= 1'b0;
      if (!ser_active)
        ser_cnt <= 4'h0;
      else if (b3_s && !sclk_prev)
      begin
        ser_shift <= {ser_shift[6:0], b2_s};
        if (ser_cnt == LAST_BIT)
        begin
          ser_word <= {ser_shift[6:0], b2_s};
          ser_cnt <= 4'h0;
          ser_done <= 1'b1;
        end
        else
          ser_cnt <= ser_cnt + 4'h1;
      end
    end
  end

  // ==========================================================
  // Reference code and pin functions
  logic [7:0] next_ref; // Code to present
  logic next_fixed; // Fixed-voltage operation

  // Code decode by mode
  always_comb
  begin
    next_ref = `VMSP_CODE_RESET;
    next_fixed = 1'b0;
    case (mode)
      vmsp_pkg::VMSP_PARALLEL:
        next_ref = {2'b00, b5_s, b4_s, b3_s, b2_s, sel_s, b0_s};
      vmsp_pkg::VMSP_SERIAL:
        if (!system_power_ok_input_s)
          next_ref = {6'h00, b3_s, b2_s};
        else if (b0_s)
        begin
          next_ref = FIXED_CODE;
          next_fixed = 1'b1;
        end
        else
          next_ref = ser_word;
      default:
        next_ref = `VMSP_CODE_RESET;
    endcase
  end

  // Registered pin controls and code
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ref_code_out <= `VMSP_CODE_RESET;
      fixed_voltage_mode_out <= 1'b0;
      pulldown_serial_pins_out <= 1'b1;
      pulldown_other_pins_out <= 1'b1;
      code_bit2_or_serial_data_out <= 1'b0;
      code_bit2_or_serial_data_oe_out <= 1'b0;
      core_enable_out <= 1'b0;
      northbridge_enable_out <= 1'b0;
      droop_enable_out <= 1'b0;
    end
    else
    begin
      ref_code_out <= next_ref;
      fixed_voltage_mode_out <= next_fixed;
      pulldown_serial_pins_out <= (mode != vmsp_pkg::VMSP_SERIAL);
      pulldown_other_pins_out <= 1'b1;
      code_bit2_or_serial_data_out <= 1'b0;
      code_bit2_or_serial_data_oe_out <= 1'b0;
      core_enable_out <= run;
      northbridge_enable_out <= run;
      droop_enable_out <= run & droop;
    end
  end

  // ==========================================================
  // Output-good indication
  logic next_good; // Good condition
  logic good_fall; // Good lost pulse

  assign next_good = run & ss_s & ~(|win_s) & ~oc_s;
  assign good_fall = outputs_good_indication_out & ~next_good;

  // Good register
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      outputs_good_indication_out <= 1'b0;
    else
      outputs_good_indication_out <= next_good;
  end

  // ==========================================================
  // Switching interval and phase pulses
  logic [15:0] per_cnt; // Position in interval
  logic start; // First cycle of interval
  logic [3:0] pulse; // Pulse states
  logic [3:0] risen; // Rose this interval
  logic [15:0] on_cnt [4]; // High cycles per phase
  logic duty_hit; // Limit reached somewhere

  assign start = (per_cnt == 16'h0000);

  // Interval counter
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      per_cnt <= 16'h0000;
    else if (!run || per_cnt == LAST_CNT)
      per_cnt <= 16'h0000;
    else
      per_cnt <= per_cnt + 16'h0001;
  end

  // Per-phase pulse generation
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pulse <= 4'h0;
      risen <= 4'h0;
      for (int i = 0; i < 4; i++)
        on_cnt[i] <= 16'h0000;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!run || start)
        begin
          pulse[i] <= 1'b0;
          risen[i] <= 1'b0;
          on_cnt[i] <= 16'h0000;
        end
        else if (pulse[i])
        begin
          if (!phase_demand_in[i] || on_cnt[i] == MAX_ON_C)
            pulse[i] <= 1'b0;
          else
            on_cnt[i] <= on_cnt[i] + 16'h0001;
        end
        else if (phase_demand_in[i] && phase_on[i] && !risen[i])
        begin
          pulse[i] <= 1'b1;
          risen[i] <= 1'b1;
          on_cnt[i] <= 16'h0001;
        end
      end
    end
  end

  // Duty limit event
  always_comb
  begin
    duty_hit = 1'b0;
    for (int i = 0; i < 4; i++)
      duty_hit = duty_hit | (pulse[i] & phase_demand_in[i] & (on_cnt[i] == MAX_ON_C));
  end

  assign phase_pulse_out = pulse[1:0];
  assign phase_three_pulse_output_out = pulse[2];
  assign phase_four_pulse_output_out = pulse[3];

  // ==========================================================
  // Northbridge gate drive with shoot-through interlock
  logic shoot_hold; // Upper held off by lower gate

  assign shoot_hold = run & northbridge_demand_in & lg_mon_s;

  // Gate registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      northbridge_upper_gate_drive_out <= 1'b0;
      northbridge_lower_gate_drive_out <= 1'b0;
    end
    else
    begin
      northbridge_lower_gate_drive_out <= run & ~northbridge_demand_in;
      northbridge_upper_gate_drive_out <= run & northbridge_demand_in & ~lg_mon_s &
                                          ~northbridge_lower_gate_drive_out;
    end
  end

  // ==========================================================
  // APB slave, status, mask and interrupt
  logic [`VMSP_EV_WIDTH-1:0] status; // Sticky events
  logic [`VMSP_EV_WIDTH-1:0] mask; // Interrupt enables
  logic [`VMSP_EV_WIDTH-1:0] events; // Event pulses
  logic xfer; // Completing access
  logic status_rd; // Status read completing

  assign events = {shoot_hold, duty_hit, ser_done, good_fall, en_rise};
  assign xfer = psel_in & penable_in & pready_out;
  assign status_rd = xfer & ~pwrite_in & (paddr_in == `VMSP_ADDR_STATUS);

  // One wait state, then ready with data
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else if (psel_in && penable_in && !pready_out)
    begin
      pready_out <= 1'b1;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      if (paddr_in == `VMSP_ADDR_STATUS)
        prdata_out <= {27'h0, status};
      else if (paddr_in == `VMSP_ADDR_MASK)
        prdata_out <= {27'h0, mask};
      else if (paddr_in == `VMSP_ADDR_STATE)
        prdata_out <= {22'h0, phase_on, droop, fixed_voltage_mode_out, system_power_ok_input_s, mode};
      else if (paddr_in == `VMSP_ADDR_CODE)
        prdata_out <= {16'h0, ser_word, ref_code_out};
      else
        pslverr_out <= 1'b1; // Unmapped address
    end
    else
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Mask register write
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      mask <= `VMSP_MASK_RESET;
    else if (xfer && pwrite_in && paddr_in == `VMSP_ADDR_MASK)
      mask <= pwdata_in[`VMSP_EV_WIDTH-1:0];
  end

  // Sticky status, set wins over read clear
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      status <= '0;
    else if (status_rd)
      status <= events;
    else
      status <= status | events;
  end

  // Level interrupt from masked status
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(status & mask);
  end

endmodule

`default_nettype wire

// ### test/vmsp_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker on the top-level pins
module vmsp_top_asserts #(
  parameter int PERIOD_CYCLES = 20
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Pins and straps
  input wire logic enable_pin_in,
  input wire logic mode_select_code_bit1_in,
  input wire logic frequency_set_strap_in,
  input wire logic soft_start_done_in,
  input wire logic overcurrent_fault_in,
  input wire logic [1:0] window_fault_in,
  input wire logic northbridge_lower_gate_drive_in,
  // Watched outputs
  input wire logic pulldown_serial_pins_out,
  input wire logic pulldown_other_pins_out,
  input wire logic code_bit2_or_serial_data_oe_out,
  input wire logic core_enable_out,
  input wire logic northbridge_enable_out,
  input wire logic droop_enable_out,
  input wire logic fixed_voltage_mode_out,
  input wire logic outputs_good_indication_out,
  input wire logic [1:0] phase_pulse_out,
  input wire logic northbridge_upper_gate_drive_out,
  input wire logic northbridge_lower_gate_drive_out
);
  // Longest pulse allowed
  localparam int MAX_ON = PERIOD_CYCLES * 933 / 1000;
  // Run length of the phase one pulse
  int high_run;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  // Count consecutive high cycles
  always_ff @(posedge ref_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      high_run <= 0;
    else if (phase_pulse_out[0])
      high_run <= high_run + 1;
    else
      high_run <= 0;
  end
  // Enable rising with select or strap held
  sequence en_rise_ser;
    !enable_pin_in ##1 (enable_pin_in && !mode_select_code_bit1_in) [*4];
  endsequence
  sequence en_rise_par;
    !enable_pin_in ##1 (enable_pin_in && mode_select_code_bit1_in) [*4];
  endsequence
  sequence en_rise_gnd;
    !enable_pin_in ##1 (enable_pin_in && !frequency_set_strap_in) [*4];
  endsequence
  a_ser_mode_pins: assert property (en_rise_ser |=> core_enable_out
    && northbridge_enable_out && !pulldown_serial_pins_out) else $error("serial entry wrong");
  a_par_mode_pins: assert property (en_rise_par |=> core_enable_out
    && pulldown_serial_pins_out && !fixed_voltage_mode_out) else $error("parallel entry wrong");
  a_droop_ground: assert property (en_rise_gnd |=> droop_enable_out)
    else $error("droop off");
  a_enable_off: assert property (!enable_pin_in [*5] |-> !core_enable_out
    && !northbridge_enable_out) else $error("controller on");
  a_mode_hold: assert property (core_enable_out && $past(core_enable_out)
    |-> $stable(pulldown_serial_pins_out)) else $error("mode moved");
  a_pull_other: assert property (pulldown_other_pins_out)
    else $error("pull-down off");
  a_data_idle: assert property (!code_bit2_or_serial_data_oe_out)
    else $error("data driven");
  a_good_soft: assert property (!soft_start_done_in [*3] |=> !outputs_good_indication_out)
    else $error("good early");
  a_good_fault: assert property ((window_fault_in != 2'b00 || overcurrent_fault_in) [*3]
    |=> !outputs_good_indication_out) else $error("good in fault");
  a_duty_cap: assert property (high_run <= MAX_ON)
    else $error("pulse too long");
  a_gate_wait: assert property (northbridge_lower_gate_drive_in [*3]
    |=> !northbridge_upper_gate_drive_out) else $error("upper early");
  a_gate_overlap: assert property (!(northbridge_upper_gate_drive_out
    && northbridge_lower_gate_drive_out)) else $error("gates overlap");
endmodule

bind vmsp_top vmsp_top_asserts #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_chk (.*);
`default_nettype wire

// ### test/vmsp_serial_master.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Processor side serial code master
module vmsp_serial_master (
  // Link pins toward the block
  output logic svc_out,
  output logic svd_out
);
  // Clock idle low, data idle high
  initial
  begin
    svc_out = 1'b0;
    svd_out = 1'b1;
  end
  // One word, first bit the top one; clock stands still after it
  task automatic send(input logic [7:0] w, input int hp);
    for (int i = 7; i >= 0; i--)
    begin
      svd_out = w[i];
      #(hp) svc_out = 1'b1;
      #(hp) svc_out = 1'b0;
    end
    // Released line without pull-down shows the inverse
    #(hp) svd_out = ~w[0];
  endtask
endmodule
`default_nettype wire

// ### test/tb_vid_mode_select_and_power_good.sv
`timescale 1ns/1ps
`default_nettype none
`include "vmsp_defs.svh"
// ====
// Bench for mode select and good logic
module tb_vid_mode_select_and_power_good;
  // Design inputs
  logic ref_clk_in = 1'b0, rst_b_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic enable_pin_in = 1'b0, mode_select_code_bit1_in = 1'b0;
  logic code_bit0_or_fixed_voltage_enable_in = 1'b0, system_power_ok_input_in = 1'b0;
  logic parallel_code_bit4_in = 1'b0, parallel_code_bit5_in = 1'b0;
  logic [1:0] window_fault_in = 2'b00;
  logic overcurrent_fault_in = 1'b0, soft_start_done_in = 1'b0, frequency_set_strap_in = 1'b0;
  logic [3:0] phase_current_sense_negative_in = 4'h8, phase_demand_in = 4'h0;
  logic northbridge_demand_in = 1'b0, northbridge_lower_gate_drive_in = 1'b1;
  wire logic code_bit2_or_serial_data_in, code_bit3_or_serial_clock_in;
  // Design outputs
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, irq_out, code_bit2_or_serial_data_out;
  logic code_bit2_or_serial_data_oe_out, pulldown_serial_pins_out, pulldown_other_pins_out;
  logic core_enable_out, northbridge_enable_out, droop_enable_out, fixed_voltage_mode_out;
  logic outputs_good_indication_out, phase_three_pulse_output_out, phase_four_pulse_output_out;
  logic northbridge_upper_gate_drive_out, northbridge_lower_gate_drive_out;
  logic [7:0] ref_code_out;
  logic [1:0] phase_pulse_out;
  // Bench state
  logic ser_on = 1'b0, pv2 = 1'b0, pv3 = 1'b0;
  wire logic svc, svd;
  logic [64:0] exp_q[$];
  logic [5:0] pv;
  logic [7:0] w;
  int fails = 0, samples_checked = 0, r0, h3, h4;
  // Pin levels: parallel code or serial master; design drive wins
  assign code_bit3_or_serial_clock_in = ser_on ? svc : pv3;
  assign code_bit2_or_serial_data_in = !ser_on ? pv2 :
    code_bit2_or_serial_data_oe_out ? code_bit2_or_serial_data_out : svd;
  vmsp_top #(.PERIOD_CYCLES(30)) u_dut (.*);
  vmsp_serial_master u_sm (.svc_out(svc), .svd_out(svd));
  always #25 ref_clk_in = ~ref_clk_in;
  // ====
  // Tasks
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %0t expected %h got %h", $time, e, g);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // One transfer; expected read data and error noted first
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic err);
    int k;
    exp_q.push_back({err, m, d & m});
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    paddr_in <= a;
    pwrite_in <= wr;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk_in);
      k++;
    end
    while (pready_out !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      cmp(32'h1, 32'h0);
      complete_run();
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  // Pulse watch, optionally toggling phase one demand
  task automatic watch(input int n, input logic tog);
    logic p;
    p = 1'b0;
    r0 = 0;
    h3 = 0;
    h4 = 0;
    repeat (n)
    begin
      @(posedge ref_clk_in);
      if (tog) phase_demand_in[0] <= ~phase_demand_in[0];
      r0 += int'(phase_pulse_out[0] && !p);
      p = phase_pulse_out[0];
      h3 += int'(phase_three_pulse_output_out);
      h4 += int'(phase_four_pulse_output_out);
    end
  endtask
  // Completed transfers against the oldest note
  always @(posedge ref_clk_in)
  begin
    if (psel_in && penable_in && pready_out === 1'b1 && exp_q.size() > 0)
    begin
      cmp(exp_q[0][31:0], prdata_out & exp_q[0][63:32]);
      cmp({31'h0, exp_q[0][64]}, {31'h0, pslverr_out});
      void'(exp_q.pop_front());
    end
  end
  // ====
  // Main sequence
  initial
  begin
    void'($urandom(81));
    tick(4);
    rst_b_in <= 1'b1;
    apb(1'b0, `VMSP_ADDR_MASK, {27'h0, `VMSP_MASK_RESET}, 32'h1f, 1'b0);
    apb(1'b0, `VMSP_ADDR_STATE, 32'h1, 32'h7, 1'b0);
    apb(1'b0, 8'h10, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 8'h14, 32'h5, 32'h0, 1'b1);
    // Parallel entry with random code
    pv = 6'($urandom());
    pv[1] = 1'b1;
    {parallel_code_bit5_in, parallel_code_bit4_in, pv3, pv2} <= {pv[5:2]};
    {mode_select_code_bit1_in, code_bit0_or_fixed_voltage_enable_in} <= pv[1:0];
    tick(3);
    enable_pin_in <= 1'b1;
    tick(8);
    cmp(32'h0, {31'h0, irq_out});
    cmp(32'h0, {31'h0, outputs_good_indication_out});
    apb(1'b1, `VMSP_ADDR_MASK, 32'h1f, 32'h0, 1'b0);
    tick(3);
    cmp(32'h1, {31'h0, irq_out});
    apb(1'b0, `VMSP_ADDR_STATUS, 32'h1, 32'h1, 1'b0);
    tick(3);
    cmp(32'h0, {31'h0, irq_out});
    apb(1'b0, `VMSP_ADDR_STATUS, 32'h0, 32'h1, 1'b0);
    apb(1'b0, `VMSP_ADDR_STATE, 32'h1e4, 32'h3ff, 1'b0);
    apb(1'b0, `VMSP_ADDR_CODE, {26'h0, pv}, 32'h3f, 1'b0);
    cmp({26'h0, pv}, {24'h0, ref_code_out});
    mode_select_code_bit1_in <= 1'b0;
    tick(6);
    apb(1'b0, `VMSP_ADDR_STATE, 32'h4, 32'h7, 1'b0);
    cmp(32'h1, {31'h0, pulldown_serial_pins_out});
    // Phases: held demand, then toggling demand
    phase_demand_in <= 4'b1101;
    watch(90, 1'b0);
    cmp(32'h0, 32'(h4));
    cmp(32'h1, 32'(h3 > 0));
    watch(60, 1'b1);
    cmp(32'h1, 32'(r0 <= 3));
    phase_demand_in <= 4'h0;
    // Northbridge gate held by lower monitor
    cmp(32'h1, {31'h0, northbridge_lower_gate_drive_out});
    northbridge_demand_in <= 1'b1;
    tick(6);
    cmp(32'h0, {31'h0, northbridge_upper_gate_drive_out});
    northbridge_lower_gate_drive_in <= 1'b0;
    tick(6);
    cmp(32'h1, {31'h0, northbridge_upper_gate_drive_out});
    apb(1'b0, `VMSP_ADDR_STATUS, 32'h10, 32'h10, 1'b0);
    northbridge_demand_in <= 1'b0;
    // Good indication and its faults
    soft_start_done_in <= 1'b1;
    tick(6);
    cmp(32'h1, {31'h0, outputs_good_indication_out});
    window_fault_in <= 2'b10;
    tick(5);
    cmp(32'h0, {31'h0, outputs_good_indication_out});
    apb(1'b0, `VMSP_ADDR_STATUS, 32'h2, 32'h2, 1'b0);
    window_fault_in <= 2'b00;
    overcurrent_fault_in <= 1'b1;
    tick(5);
    cmp(32'h0, {31'h0, outputs_good_indication_out});
    overcurrent_fault_in <= 1'b0;
    enable_pin_in <= 1'b0;
    tick(6);
    cmp(32'h0, {31'h0, core_enable_out});
    // Serial entry, boot code, then words
    {code_bit0_or_fixed_voltage_enable_in, frequency_set_strap_in, ser_on} <= 3'b011;
    tick(4);
    enable_pin_in <= 1'b1;
    tick(8);
    apb(1'b0, `VMSP_ADDR_STATE, 32'h1c2, 32'h3ff, 1'b0);
    cmp(32'h0, {31'h0, pulldown_serial_pins_out});
    cmp(32'h0, {31'h0, code_bit2_or_serial_data_out});
    apb(1'b0, `VMSP_ADDR_CODE, 32'h1, 32'hff, 1'b0);
    system_power_ok_input_in <= 1'b1;
    w = 8'($urandom());
    #7 u_sm.send(w, 200);
    tick(6);
    {parallel_code_bit5_in, parallel_code_bit4_in} <= ~{parallel_code_bit5_in, parallel_code_bit4_in};
    tick(5);
    apb(1'b0, `VMSP_ADDR_CODE, {16'h0, w, w}, 32'hffff, 1'b0);
    apb(1'b0, `VMSP_ADDR_STATUS, 32'h4, 32'h4, 1'b0);
    code_bit0_or_fixed_voltage_enable_in <= 1'b1;
    tick(5);
    apb(1'b0, `VMSP_ADDR_STATE, 32'h10, 32'h10, 1'b0);
    w = ~w;
    #7 u_sm.send(w, 200);
    tick(6);
    apb(1'b0, `VMSP_ADDR_CODE, {16'h0, w, `VMSP_FIXED_CODE}, 32'hffff, 1'b0);
    cmp({24'h0, `VMSP_FIXED_CODE}, {24'h0, ref_code_out});
    tick(4);
    complete_run();
  end
endmodule
`default_nettype wire
